//--- pkg/pecl_defines.svh
// Offsets, field positions, reset values and timing counts of the
// per-port error counter and indicator control bank.
// Assumes a 200 MHz system clock and register-level management access.
`ifndef PECL_DEFINES_SVH
`define PECL_DEFINES_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define PECL_ADDR_RX_ERROR_FRAME   5'h15
`define PECL_ADDR_RX_SYMBOL_ERROR  5'h16
`define PECL_ADDR_RX_PREMATURE_END 5'h17
`define PECL_ADDR_RX_EOF_ERROR     5'h18
`define PECL_ADDR_TX_JABBER        5'h19
`define PECL_ADDR_RESERVED_SLOT    5'h1a
`define PECL_ADDR_LED_JABBER_CTRL  5'h1b

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define PECL_NUM_COUNTERS          5
`define PECL_CNT_FULL              16'hffff
`define PECL_CNT_ZERO              16'h0000
`define PECL_CNT_ONE               16'h0001
`define PECL_CTRL_BLINK_OFF_BIT    4
`define PECL_CTRL_CRS_CUT_BIT      3
`define PECL_CTRL_SEL_HI           2
`define PECL_CTRL_SEL_LO           0
`define PECL_CTRL_RESET            5'h00
`define PECL_RSVD_READ             16'h0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PECL_CLK_MHZ               200
`define PECL_BLINK_HALF_MS         50
`define PECL_BLINK_HALF_CYCLES     (`PECL_BLINK_HALF_MS * `PECL_CLK_MHZ * 1000)

`endif

//--- pkg/pecl_pkg.sv
// Types shared by the error counter and indicator control bank.
// Assumes the defines header is compiled alongside.
`default_nettype none

package pecl_pkg;

    // Line-side event pulses, one cycle each
    typedef struct packed {
        logic rx100_sym_err;    // Symbol error seen
        logic rx100_frame_end;  // Receive frame has ended
        logic rx100_tr_seen;    // T/R pair closed the frame (with frame_end)
        logic rx10_eof_err;     // 10 Mb/s end-of-frame error
        logic tx10_jabber;      // 10 Mb/s jabber detected
    } pecl_evt_t;

    // Line status levels
    typedef struct packed {
        logic link;
        logic activity;
        logic speed_100;
        logic collision;
        logic fast_jabber;      // PHY in 100 Mb/s jabber
        logic crs;              // Raw carrier sense
    } pecl_line_t;

    // Indicator drive, high lights the lamp
    typedef struct packed {
        logic first_indicator;
        logic second_indicator;
        logic third_indicator;
    } pecl_led_t;

    typedef enum logic [2:0] {
        PECL_SEL_LNKACT_SPD_COL,
        PECL_SEL_COL_SPD_SPD,
        PECL_SEL_LNK_SPD_SPD,
        PECL_SEL_COL_SPD_ACT,
        PECL_SEL_OFF_SPD_OFF,
        PECL_SEL_ON_SPD_OFF,
        PECL_SEL_OFF_SPD_ON,
        PECL_SEL_ON_SPD_ON
    } pecl_sel_t;

endpackage

`default_nettype wire

//--- design/pecl_top.sv
// Per-port error counters, indicator select and carrier sense cut.
// Assumes event pulses and line levels are synchronous to sys_clk and
// that management framing is decoded outside into read/write strobes.
`include "pecl_defines.svh"
`default_nettype none

module pecl_top
    import pecl_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYCLES = `PECL_BLINK_HALF_CYCLES
) (
    input  wire logic        sys_clk,      // 200 MHz clock
    input  wire logic        rst_b,        // Synchronous reset, active low
    input  wire logic [4:0]  mgmt_addr,    // Register address
    input  wire logic        mgmt_rd,      // Read strobe, one cycle
    input  wire logic        mgmt_wr,      // Write strobe, one cycle
    input  wire logic [15:0] mgmt_wdata,   // Write data
    output logic      [15:0] mgmt_rdata,   // Read data, registered
    output logic             mgmt_rvalid,  // Read data valid, one cycle
    input  wire pecl_evt_t   evt,          // Event pulses
    input  wire pecl_line_t  line,         // Line status levels
    output pecl_led_t        led,          // Indicator drive
    output logic             crs_out       // Carrier sense after jabber cut
);

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic [4:0] ctrl_reg;
    logic       blink_off;
    logic       crs_cut_en;
    pecl_sel_t  sel;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrl_reg <= `PECL_CTRL_RESET;
        end else if (mgmt_wr && mgmt_addr == `PECL_ADDR_LED_JABBER_CTRL) begin
            ctrl_reg <= mgmt_wdata[4:0];
        end
    end

    assign blink_off  = ctrl_reg[`PECL_CTRL_BLINK_OFF_BIT];
    assign crs_cut_en = ctrl_reg[`PECL_CTRL_CRS_CUT_BIT];
    assign sel        = pecl_sel_t'(ctrl_reg[`PECL_CTRL_SEL_HI:`PECL_CTRL_SEL_LO]);

    // ------------------------------------------------------------------
    // Frame error tracking
    // ------------------------------------------------------------------
    // Any error inside a frame marks it once, however many errors follow
    logic frame_err_reg;
    logic premature_end;
    logic frame_bad;

    assign premature_end = evt.rx100_frame_end && !evt.rx100_tr_seen;
    assign frame_bad     = evt.rx100_frame_end
                           && (frame_err_reg || evt.rx100_sym_err || premature_end);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            frame_err_reg <= 1'b0;
        end else if (evt.rx100_frame_end) begin
            frame_err_reg <= 1'b0;
        end else if (evt.rx100_sym_err) begin
            frame_err_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Saturating read-clear counters
    // ------------------------------------------------------------------
    logic [`PECL_NUM_COUNTERS-1:0] cnt_inc;
    logic [`PECL_NUM_COUNTERS-1:0] cnt_rd;
    logic [15:0]                   cnt_reg [`PECL_NUM_COUNTERS];

    assign cnt_inc[0] = frame_bad;
    assign cnt_inc[1] = evt.rx100_sym_err;
    assign cnt_inc[2] = premature_end;
    assign cnt_inc[3] = evt.rx10_eof_err;
    assign cnt_inc[4] = evt.tx10_jabber;

    genvar gi;
    generate
        for (gi = 0; gi < `PECL_NUM_COUNTERS; gi++) begin : g_cnt
            assign cnt_rd[gi] = mgmt_rd
                && mgmt_addr == `PECL_ADDR_RX_ERROR_FRAME + 5'(gi);
            always_ff @(posedge sys_clk) begin
                if (!rst_b) begin
                    cnt_reg[gi] <= `PECL_CNT_ZERO;
                end else if (cnt_rd[gi]) begin
                    // Event during the read is kept for the next read
                    cnt_reg[gi] <= cnt_inc[gi] ? `PECL_CNT_ONE
                                               : `PECL_CNT_ZERO;
                end else if (cnt_inc[gi] && cnt_reg[gi] != `PECL_CNT_FULL) begin
                    cnt_reg[gi] <= cnt_reg[gi] + `PECL_CNT_ONE;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Management read path
    // ------------------------------------------------------------------
    logic [15:0] rdata_next;

    always_comb begin
        rdata_next = `PECL_CNT_ZERO;
        case (mgmt_addr)
            `PECL_ADDR_RX_ERROR_FRAME:   rdata_next = cnt_reg[0];
            `PECL_ADDR_RX_SYMBOL_ERROR:  rdata_next = cnt_reg[1];
            `PECL_ADDR_RX_PREMATURE_END: rdata_next = cnt_reg[2];
            `PECL_ADDR_RX_EOF_ERROR:     rdata_next = cnt_reg[3];
            `PECL_ADDR_TX_JABBER:        rdata_next = cnt_reg[4];
            `PECL_ADDR_RESERVED_SLOT:    rdata_next = `PECL_RSVD_READ;
            `PECL_ADDR_LED_JABBER_CTRL:  rdata_next = {11'h000, ctrl_reg};
            default:                     rdata_next = `PECL_CNT_ZERO;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            mgmt_rdata  <= `PECL_CNT_ZERO;
            mgmt_rvalid <= 1'b0;
        end else begin
            mgmt_rvalid <= mgmt_rd;
            if (mgmt_rd) begin
                mgmt_rdata <= rdata_next;
            end
        end
    end

    // ------------------------------------------------------------------
    // Blink divider
    // ------------------------------------------------------------------
    // Long count kept as a parameter so simulation can shorten it
    logic [31:0] blink_cnt_reg;
    logic        blink_phase_reg;
    logic        blink_tick;

    assign blink_tick = (blink_cnt_reg == BLINK_HALF_CYCLES - 1);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            blink_cnt_reg   <= 32'h0000_0000;
            blink_phase_reg <= 1'b0;
        end else if (blink_tick) begin
            blink_cnt_reg   <= 32'h0000_0000;
            blink_phase_reg <= !blink_phase_reg;
        end else begin
            blink_cnt_reg   <= blink_cnt_reg + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------
    // Indicators and carrier sense
    // ------------------------------------------------------------------
    logic      act_lamp;
    pecl_led_t led_next;

    // Activity flashes with the divider unless blinking is disabled
    assign act_lamp = line.activity && (blink_off || blink_phase_reg);

    always_comb begin
        led_next.second_indicator = line.speed_100;
        led_next.first_indicator  = 1'b0;
        led_next.third_indicator  = 1'b0;
        case (sel)
            PECL_SEL_LNKACT_SPD_COL: begin
                led_next.first_indicator = line.link && !act_lamp;
                led_next.third_indicator = line.collision;
            end
            PECL_SEL_COL_SPD_SPD: begin
                led_next.first_indicator = line.collision;
                led_next.third_indicator = line.speed_100;
            end
            PECL_SEL_LNK_SPD_SPD: begin
                led_next.first_indicator = line.link;
                led_next.third_indicator = line.speed_100;
            end
            PECL_SEL_COL_SPD_ACT: begin
                led_next.first_indicator = line.collision;
                led_next.third_indicator = act_lamp;
            end
            PECL_SEL_OFF_SPD_OFF: begin
                led_next.first_indicator = 1'b0;
                led_next.third_indicator = 1'b0;
            end
            PECL_SEL_ON_SPD_OFF: begin
                led_next.first_indicator = 1'b1;
                led_next.third_indicator = 1'b0;
            end
            PECL_SEL_OFF_SPD_ON: begin
                led_next.first_indicator = 1'b0;
                led_next.third_indicator = 1'b1;
            end
            PECL_SEL_ON_SPD_ON: begin
                led_next.first_indicator = 1'b1;
                led_next.third_indicator = 1'b1;
            end
            default: begin
                led_next.first_indicator = 1'b0;
                led_next.third_indicator = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            led     <= '0;
            crs_out <= 1'b0;
        end else begin
            led     <= led_next;
            crs_out <= line.crs && !(crs_cut_en && line.fast_jabber);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_frame_once;
        @(posedge sys_clk) disable iff (!rst_b)
        evt.rx100_sym_err && !evt.rx100_frame_end ##1
        (evt.rx100_sym_err && evt.rx100_frame_end && !cnt_rd[0]
         && cnt_reg[0] != `PECL_CNT_FULL)
        |=> cnt_reg[0] == $past(cnt_reg[0]) + `PECL_CNT_ONE;
    endproperty
    a_frame_once: assert property (p_frame_once)
        else $error("Errored frame not counted exactly once");

    property p_clean_frame;
        @(posedge sys_clk) disable iff (!rst_b)
        evt.rx100_frame_end && evt.rx100_tr_seen && !frame_err_reg
        && !evt.rx100_sym_err && !cnt_rd[0] |=> $stable(cnt_reg[0]);
    endproperty
    a_clean_frame: assert property (p_clean_frame)
        else $error("Clean frame counted as errored");

    property p_saturate;
        @(posedge sys_clk) disable iff (!rst_b)
        cnt_reg[1] == `PECL_CNT_FULL && !cnt_rd[1] |=> cnt_reg[1] == `PECL_CNT_FULL;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("Symbol error counter wrapped");

    property p_sym_inc;
        @(posedge sys_clk) disable iff (!rst_b)
        evt.rx100_sym_err && !cnt_rd[1] && cnt_reg[1] != `PECL_CNT_FULL
        |=> cnt_reg[1] == $past(cnt_reg[1]) + `PECL_CNT_ONE;
    endproperty
    a_sym_inc: assert property (p_sym_inc)
        else $error("Symbol error not counted");

    property p_premature;
        @(posedge sys_clk) disable iff (!rst_b)
        evt.rx100_frame_end && !evt.rx100_tr_seen && !cnt_rd[2]
        && cnt_reg[2] != `PECL_CNT_FULL
        |=> cnt_reg[2] == $past(cnt_reg[2]) + `PECL_CNT_ONE;
    endproperty
    a_premature: assert property (p_premature)
        else $error("Premature end not counted");

    property p_eof_jab;
        @(posedge sys_clk) disable iff (!rst_b)
        evt.rx10_eof_err && !cnt_rd[3] && !evt.tx10_jabber && !cnt_rd[4]
        && cnt_reg[3] != `PECL_CNT_FULL
        |=> cnt_reg[3] == $past(cnt_reg[3]) + `PECL_CNT_ONE && $stable(cnt_reg[4]);
    endproperty
    a_eof_jab: assert property (p_eof_jab)
        else $error("End-of-frame or jabber counter misbehaved");

    property p_read_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        mgmt_rd && mgmt_addr == `PECL_ADDR_TX_JABBER && !evt.tx10_jabber
        |=> mgmt_rvalid && mgmt_rdata == $past(cnt_reg[4])
            && cnt_reg[4] == `PECL_CNT_ZERO;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("Read did not return and clear the count");

    property p_read_and_inc;
        @(posedge sys_clk) disable iff (!rst_b)
        cnt_rd[1] && evt.rx100_sym_err |=> cnt_reg[1] == `PECL_CNT_ONE;
    endproperty
    a_read_and_inc: assert property (p_read_and_inc)
        else $error("Event lost or doubled during read");

    property p_reset_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(rst_b) |-> cnt_reg[0] == `PECL_CNT_ZERO && cnt_reg[4] == `PECL_CNT_ZERO;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("Counters not zero after reset");

    property p_no_blink;
        @(posedge sys_clk) disable iff (!rst_b)
        blink_off && sel == PECL_SEL_COL_SPD_ACT && line.activity
        |=> led.third_indicator;
    endproperty
    a_no_blink: assert property (p_no_blink)
        else $error("Activity lamp blinked with blinking disabled");

    property p_crs_cut;
        @(posedge sys_clk) disable iff (!rst_b)
        line.crs |=> crs_out == !($past(crs_cut_en) && $past(line.fast_jabber));
    endproperty
    a_crs_cut: assert property (p_crs_cut)
        else $error("Carrier sense cut wrong");

    property p_led_sel;
        @(posedge sys_clk) disable iff (!rst_b)
        sel == PECL_SEL_ON_SPD_OFF |=> led.first_indicator && !led.third_indicator
            && led.second_indicator == $past(line.speed_100);
    endproperty
    a_led_sel: assert property (p_led_sel)
        else $error("Indicator select mapping wrong");

    c_sat:     cover property (@(posedge sys_clk) disable iff (!rst_b)
                   cnt_reg[1] == `PECL_CNT_FULL && evt.rx100_sym_err);
    c_coinc:   cover property (@(posedge sys_clk) disable iff (!rst_b)
                   cnt_rd[1] && cnt_inc[1]);
    c_prem:    cover property (@(posedge sys_clk) disable iff (!rst_b) premature_end);
    c_crs_cut: cover property (@(posedge sys_clk) disable iff (!rst_b)
                   line.crs && crs_cut_en && line.fast_jabber);

endmodule

`default_nettype wire

//--- bench/pecl_mgmt_model.sv
// Management station model: one-cycle read and write strobes on the bank.
// Assumes the bank answers each read with rvalid one cycle after the strobe.
`default_nettype none

module pecl_mgmt_model (
    input  wire logic        sys_clk,     // Bank clock
    output logic      [4:0]  mgmt_addr,   // Register address
    output logic             mgmt_rd,     // Read strobe
    output logic             mgmt_wr,     // Write strobe
    output logic      [15:0] mgmt_wdata,  // Write data
    input  wire logic [15:0] mgmt_rdata,  // Read data
    input  wire logic        mgmt_rvalid  // Read data valid
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [4:0]  last_addr;
    logic [15:0] last_data;

    initial begin
        mgmt_addr  = 5'h00;
        mgmt_rd    = 1'b0;
        mgmt_wr    = 1'b0;
        mgmt_wdata = 16'h0000;
        last_addr  = 5'h00;
        last_data  = 16'h0000;
    end

    // Reserved slot data is never kept
    always @(posedge sys_clk) begin
        if (mgmt_rvalid === 1'b1 && last_addr !== 5'h1a) begin
            last_data <= mgmt_rdata;
        end
    end

    // Address and data flipped on release, so nothing leans on stale values
    task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        mgmt_addr  <= a;
        mgmt_wdata <= d;
        mgmt_wr    <= 1'b1;
        @(posedge sys_clk);
        mgmt_wr    <= 1'b0;
        mgmt_addr  <= ~a;
        mgmt_wdata <= ~d;
    endtask

    task automatic reg_read(input logic [4:0] a);
        @(posedge sys_clk);
        last_addr <= a;
        mgmt_addr <= a;
        mgmt_rd   <= 1'b1;
        @(posedge sys_clk);
        mgmt_rd   <= 1'b0;
        mgmt_addr <= ~a;
    endtask

endmodule

`default_nettype wire

//--- bench/pecl_top_test.sv
// Self-checking bench for the error counter and indicator bank.
// Assumes the management model above and a short blink half period.
`default_nettype none

module pecl_top_test
    import pecl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int HALF = 4;

    typedef struct packed {
        logic        care;
        logic [15:0] val;
    } pecl_exp_t;

    logic        sys_clk;
    logic        rst_b;
    logic [4:0]  mgmt_addr;
    logic        mgmt_rd;
    logic        mgmt_wr;
    logic [15:0] mgmt_wdata;
    logic [15:0] mgmt_rdata;
    logic        mgmt_rvalid;
    pecl_evt_t   evt;
    pecl_line_t  line;
    pecl_led_t   led;
    logic        crs_out;
    pecl_exp_t   exp_q[$];
    pecl_exp_t   cur;
    int          err_total;
    int          n_tests;
    int          n;
    int          e15;
    int          e16;
    int          e17;
    logic        pend;
    logic        tr;
    logic [31:0] r;
    logic [5:0]  ln;
    logic        f;
    logic        t;
    logic [4:0]  ad[3] = '{5'h16, 5'h18, 5'h19};
    logic [4:0]  ev[3] = '{5'h10, 5'h02, 5'h01};

    pecl_top #(.BLINK_HALF_CYCLES(HALF)) DUT (
        .sys_clk(sys_clk), .rst_b(rst_b), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd),
        .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
        .mgmt_rvalid(mgmt_rvalid), .evt(evt), .line(line), .led(led), .crs_out(crs_out)
    );

    pecl_mgmt_model mgr (
        .sys_clk(sys_clk), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr),
        .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid)
    );

    // ------------------------------------------------------------------
    // Clock, watchdog, shared tasks
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (90000) @(posedge sys_clk);
        err_total++;
        $display("ERROR watchdog expected finish seen hang");
        tally_and_finish();
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] v, input logic care);
        exp_q.push_back('{care, v});
        mgr.reg_read(a);
    endtask

    task automatic pulse(input logic [4:0] e);
        @(posedge sys_clk);
        evt <= pecl_evt_t'(e);
        @(posedge sys_clk);
        evt <= '0;
    endtask

    // Bounded wait for all pending reads to come back
    task automatic done_test(input string nm);
        for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge sys_clk);
        if (exp_q.size() != 0) begin
            err_total++;
            $display("ERROR read queue expected 0 seen %0d", exp_q.size());
            tally_and_finish();
        end else begin
            $display("test %s finished", nm);
        end
    endtask

    // Read data checker: oldest note against each returned word
    always @(posedge sys_clk) begin
        if (mgmt_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected rvalid", 16'h0000, 16'h0001);
            end else begin
                cur = exp_q.pop_front();
                if (cur.care) check("read data", cur.val, mgmt_rdata);
            end
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        evt = '0;
        line = '0;
        err_total = 0;
        n_tests = 0;
        void'($urandom(16));
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;

        for (int a = 'h15; a <= 'h1b; a++) rd(a[4:0], 16'h0000, a != 'h1a);
        rd(5'h00, 16'h0000, 1'b1);
        done_test("reset");

        // Writes to counters must not land
        for (int i = 0; i < 3; i++) begin
            n = 1 + $urandom_range(0, 9);
            repeat (n) pulse(ev[i]);
            mgr.reg_write(ad[i], 16'hffff);
            rd(ad[i], n[15:0], 1'b1);
            rd(ad[i], 16'h0000, 1'b1);
        end
        done_test("single counters");

        // Loose symbol errors above mark the first frame as errored
        pend = 1'b1;
        e15 = 0;
        e16 = 0;
        e17 = 0;
        for (int i = 0; i < 8; i++) begin
            n = $urandom_range(0, 2);
            tr = $urandom_range(0, 1);
            repeat (n) pulse(5'h10);
            pulse(tr ? 5'h0c : 5'h08);
            e15 += (pend || n > 0 || !tr);
            e16 += n;
            e17 += !tr;
            pend = 1'b0;
        end
        // Error, then error with the closing pair in the next cycle: one frame
        @(posedge sys_clk);
        evt <= pecl_evt_t'(5'h10);
        @(posedge sys_clk);
        evt <= pecl_evt_t'(5'h1c);
        @(posedge sys_clk);
        evt <= '0;
        e15 += 1;
        e16 += 2;
        rd(5'h15, e15[15:0], 1'b1);
        rd(5'h16, e16[15:0], 1'b1);
        rd(5'h17, e17[15:0], 1'b1);
        done_test("frames");

        repeat (3) pulse(5'h10);
        exp_q.push_back('{1'b1, 16'h0003});
        fork
            mgr.reg_read(5'h16);
            pulse(5'h10);
        join
        rd(5'h16, 16'h0001, 1'b1);
        done_test("read with event");

        for (int s = 0; s < 8; s++) begin
            r = $urandom();
            mgr.reg_write(5'h1b, {r[15:5], 1'b1, 1'b0, s[2:0]});
            rd(5'h1b, {11'h000, 1'b1, 1'b0, s[2:0]}, 1'b1);
            ln = $urandom_range(0, 63);
            if (s == 0) ln[5] = 1'b1;
            @(posedge sys_clk);
            line <= pecl_line_t'(ln);
            repeat (3) @(posedge sys_clk);
            #1;
            case (s)
                0: begin f = ln[5] && !ln[4]; t = ln[2]; end
                1: begin f = ln[2]; t = ln[3]; end
                2: begin f = ln[5]; t = ln[3]; end
                3: begin f = ln[2]; t = ln[4]; end
                default: begin f = s[0]; t = s[1]; end
            endcase
            check("indicators", {13'h0000, f, ln[3], t}, {13'h0000, led});
        end
        done_test("indicator select");

        // Activity lamp: half lit while blinking, steady when blink is off
        for (int b = 0; b < 2; b++) begin
            mgr.reg_write(5'h1b, {11'h000, b[0], 4'h3});
            @(posedge sys_clk);
            line <= pecl_line_t'(6'h10);
            repeat (4) @(posedge sys_clk);
            n = 0;
            for (int c = 0; c < 4 * HALF; c++) begin
                @(posedge sys_clk);
                #1;
                n += led.third_indicator;
            end
            check("lit cycles", b ? 16'h0010 : 16'h0008, n[15:0]);
        end
        done_test("blink");

        for (int j = 0; j < 4; j++) begin
            mgr.reg_write(5'h1b, {12'h000, j[1], 3'h0});
            @(posedge sys_clk);
            line <= pecl_line_t'({4'h0, j[0], 1'b1});
            repeat (3) @(posedge sys_clk);
            #1;
            check("carrier sense", {15'h0000, !(j[1] && j[0])}, {15'h0000, crs_out});
        end
        done_test("carrier cut");

        @(posedge sys_clk);
        evt <= pecl_evt_t'(5'h1b);
        repeat (65537) @(posedge sys_clk);
        evt <= '0;
        for (int a = 'h15; a <= 'h19; a++) rd(a[4:0], 16'hffff, 1'b1);
        done_test("saturation");

        tally_and_finish();
    end

endmodule

`default_nettype wire
